// File: design/cod_pkg.sv
// Package for the clock-output and oscillator-enable block.
// Holds register indices, byte addresses, field positions, reset values and source codes.
// Assumes a 32-bit AHB-Lite slave whose registers sit on word addresses of four times the index.
package cod_pkg;

   // Register indices as printed; the byte address is four times the index.
   localparam logic [29:0] COD_SRC_SEL_IDX = 30'h0000_5060;
   localparam logic [29:0] COD_OSC_CTL_IDX = 30'h0000_5061;
   localparam logic [29:0] COD_OUT_A_IDX = 30'h0000_5064;
   localparam logic [29:0] COD_OUT_B_IDX = 30'h0000_5065;

   // Byte addresses derived from the indices.
   localparam logic [31:0] COD_SRC_SEL_ADDR = {COD_SRC_SEL_IDX, 2'b00};
   localparam logic [31:0] COD_OSC_CTL_ADDR = {COD_OSC_CTL_IDX, 2'b00};
   localparam logic [31:0] COD_OUT_A_ADDR = {COD_OUT_A_IDX, 2'b00};
   localparam logic [31:0] COD_OUT_B_ADDR = {COD_OUT_B_IDX, 2'b00};

   // Number of clock-output channels and of oscillator clocks.
   localparam int COD_CHANNELS = 2;
   localparam int COD_OSCS = 3;

   // Field positions in the source select register.
   localparam int COD_LS_CHOICE_BIT = 4;

   // Field positions in the oscillator enable register.
   localparam int COD_EXT_ON_BIT = 0;
   localparam int COD_LOW_ON_BIT = 1;
   localparam int COD_FAST_ON_BIT = 2;

   // Field positions in each clock-output control register.
   localparam int COD_OUT_ON_BIT = 0;
   localparam int COD_OUT_SRC_LSB = 2;
   localparam int COD_OUT_DIV_LSB = 4;

   // Reset values of every stored field.
   localparam logic COD_LS_CHOICE_RST = 1'b1;
   localparam logic COD_EXT_ON_RST = 1'b0;
   localparam logic COD_LOW_ON_RST = 1'b0;
   localparam logic COD_FAST_ON_RST = 1'b1;
   localparam logic COD_OUT_ON_RST = 1'b0;
   localparam logic [1:0] COD_OUT_SRC_RST = 2'h0;
   localparam logic [2:0] COD_OUT_DIV_RST = 3'h0;

   // The only transfer size that writes a register.
   localparam logic [2:0] COD_HSIZE_WORD = 3'h2;

   // Oscillator clock codes, shared by output source and system clock source.
   typedef enum logic [1:0]
   {
      COD_SRC_FAST = 2'h0,
      COD_SRC_LOW = 2'h1,
      COD_SRC_EXT = 2'h2,
      COD_SRC_RSVD = 2'h3
   } cod_src_t;

endpackage : cod_pkg

// File: design/cod_out_channel.sv
// One clock-output channel: picks a sampled oscillator level, divides it and drives the pin.
// Assumes the oscillator levels arrive already synchronised to hclk and that the
// oscillators run well below half the hclk rate.
`timescale 1ns/1ps

module cod_out_channel
   import cod_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] osc_level,
   input wire logic enable,
   input wire logic [1:0] source,
   input wire logic [2:0] divider,
   output logic clk_out
);

   // Settings in use; they follow the register only at a period boundary.
   logic act_on;
   logic [1:0] act_src;
   logic [2:0] act_div;
   // Level of the selected source and its value one cycle before.
   logic src_level;
   logic src_prev;
   // Count of source rising edges within the output period.
   logic [6:0] edge_count;
   logic [6:0] next_count;
   logic src_rise;
   logic boundary;
   // Count held at the last source rise of a period of 2^n rises.
   logic [6:0] last_count;

   // The reserved code selects no clock, so the level stays low.
   always_comb
   begin
      src_level = (act_src == COD_SRC_RSVD) ? 1'b0 : osc_level[act_src];
   end

   // Remembers the previous source level for edge detection.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         src_prev <= 1'b0;
      else
         src_prev <= src_level;
   end

   // A new period starts on the rise that completes the old one, on any rise while off, or on every cycle while the reserved code is in use.
   // Waiting for the full count keeps the low phase as long as the high phase.
   assign src_rise = src_level & ~src_prev;
   assign last_count = ~(7'h7f << act_div);
   assign boundary = ~clk_out & ((src_rise & (~act_on | (edge_count == last_count)))
      | (act_src == COD_SRC_RSVD));
   assign next_count = edge_count + 7'h01;

   // Takes new settings only at a boundary so no short pulse appears.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         act_on <= COD_OUT_ON_RST;
         act_src <= COD_OUT_SRC_RST;
         act_div <= COD_OUT_DIV_RST;
      end
      else if (boundary)
      begin
         // A source change parks the pin low until the new source's next rise.
         act_on <= enable & (source == act_src);
         act_src <= source;
         act_div <= divider;
      end
   end

   // Counts source edges; restarts at each boundary.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         edge_count <= 7'h00;
      else if (boundary)
         edge_count <= 7'h00;
      else if (src_rise)
         edge_count <= next_count;
   end

   // Drives the pin: the source itself for 1/1, else the counter bit for 1/2^n.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         clk_out <= 1'b0;
      else if (boundary)
         clk_out <= enable & (source == act_src) & (source != COD_SRC_RSVD) & src_rise;
      else if (!act_on)
         clk_out <= 1'b0;
      else if (act_div == 3'h0)
         clk_out <= src_level;
      else if (src_rise)
         clk_out <= ~next_count[act_div - 3'h1];
   end

endmodule : cod_out_channel

// File: design/cod_clock_out.sv
// Top of the clock-output and oscillator-enable block, an AHB-Lite slave.
// Assumes a single hclk domain; oscillator clocks arrive as plain pins and are sampled,
// and the system clock source code comes from the clock switcher on hclk.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps

module cod_clock_out
   import cod_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [1:0] sys_clk_source,
   input wire logic internal_fast_osc_clk,
   input wire logic low_speed_osc_clk,
   input wire logic ext_high_speed_osc_clk,
   output logic internal_fast_osc_on,
   output logic low_speed_osc_on,
   output logic ext_high_speed_osc_on,
   output logic low_speed_source_choice,
   output logic clk_out_a,
   output logic clk_out_b
);

   // Raw oscillator pins, indexed by their source code.
   logic [COD_OSCS-1:0] osc_raw;
   // Oscillator levels after two flip-flops.
   logic [COD_OSCS-1:0] osc_sync;

   // Address-phase capture for the following data phase.
   logic wr_pend;
   logic [29:0] wr_index;
   logic take;

   // Clock-output settings, one entry per channel.
   logic [COD_CHANNELS-1:0] ch_on;
   logic [COD_CHANNELS-1:0][1:0] ch_src;
   logic [COD_CHANNELS-1:0][2:0] ch_div;

   // Next values of every stored field, as they will be after this edge.
   logic next_ls_choice;
   logic next_ext_on;
   logic next_low_on;
   logic next_fast_on;
   logic [COD_CHANNELS-1:0] next_ch_on;
   logic [COD_CHANNELS-1:0][1:0] next_ch_src;
   logic [COD_CHANNELS-1:0][2:0] next_ch_div;

   // Byte that a read in the current address phase returns.
   logic [7:0] rd_byte;
   // Low byte of the write data, the only lane the registers use.
   logic [7:0] wbyte;

   // Source code order: fast, low-speed, external.
   assign osc_raw = {ext_high_speed_osc_clk, low_speed_osc_clk, internal_fast_osc_clk};
   assign wbyte = hwdata[7:0];

   // Each oscillator pin passes two flip-flops before any logic reads it.
   genvar gi;
   generate
      for (gi = 0; gi < COD_OSCS; gi = gi + 1)
      begin : g_sync
         // The first stage feeds the second stage only.
         logic stage1;
         logic stage2;

         // Two-stage synchroniser for one oscillator level.
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end
            else
            begin
               stage1 <= osc_raw[gi];
               stage2 <= stage1;
            end
         end

         assign osc_sync[gi] = stage2;
      end
   endgenerate

   // A transfer is taken when selected, active and the bus is ready.
   assign take = hsel & htrans[1] & hready;

   // Captures a word write in the address phase; it completes in the data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;
         wr_index <= 30'h0000_0000;
      end
      else
      begin
         // Only whole-word writes reach the registers.
         wr_pend <= take & hwrite & (hsize == COD_HSIZE_WORD);
         // The index is kept only when a transfer is taken.
         if (take)
            wr_index <= haddr[31:2];
      end
   end

   // The slave never waits and never errors, so these flops hold constants.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Works out the next value of the system-wide control fields.
   always_comb
   begin
      next_ls_choice = low_speed_source_choice;
      next_ext_on = ext_high_speed_osc_on;
      next_low_on = low_speed_osc_on;
      next_fast_on = internal_fast_osc_on;
      // Source select register: only the low-speed choice bit is stored here.
      if (wr_pend && (wr_index == COD_SRC_SEL_IDX))
      begin
         next_ls_choice = wbyte[COD_LS_CHOICE_BIT];
      end
      // Oscillator enable register: a running system clock source is never cleared.
      if (wr_pend && (wr_index == COD_OSC_CTL_IDX))
      begin
         next_ext_on = wbyte[COD_EXT_ON_BIT] | (sys_clk_source == COD_SRC_EXT);
         next_low_on = wbyte[COD_LOW_ON_BIT] | (sys_clk_source == COD_SRC_LOW);
         next_fast_on = wbyte[COD_FAST_ON_BIT] | (sys_clk_source == COD_SRC_FAST);
      end
   end

   // Works out the next value of each channel's fields; bits 7 and 1 are dropped.
   always_comb
   begin
      next_ch_on = ch_on;
      next_ch_src = ch_src;
      next_ch_div = ch_div;
      for (int c = 0; c < COD_CHANNELS; c++)
      begin
         // Channel c sits at the channel A index plus c.
         if (wr_pend && (wr_index == (COD_OUT_A_IDX + 30'(c))))
         begin
            next_ch_on[c] = wbyte[COD_OUT_ON_BIT];
            next_ch_src[c] = wbyte[COD_OUT_SRC_LSB +: 2];
            next_ch_div[c] = wbyte[COD_OUT_DIV_LSB +: 3];
         end
      end
   end

   // Oscillator enable flops; these drive the oscillator circuits directly.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ext_high_speed_osc_on <= COD_EXT_ON_RST;
         low_speed_osc_on <= COD_LOW_ON_RST;
         internal_fast_osc_on <= COD_FAST_ON_RST;
      end
      else
      begin
         ext_high_speed_osc_on <= next_ext_on;
         low_speed_osc_on <= next_low_on;
         internal_fast_osc_on <= next_fast_on;
      end
   end

   // Low-speed source choice flop; software sets it before enabling that oscillator.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         low_speed_source_choice <= COD_LS_CHOICE_RST;
      else
         low_speed_source_choice <= next_ls_choice;
   end

   // Clock-output control flops for both channels.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ch_on <= {COD_CHANNELS{COD_OUT_ON_RST}};
         ch_src <= {COD_CHANNELS{COD_OUT_SRC_RST}};
         ch_div <= {COD_CHANNELS{COD_OUT_DIV_RST}};
      end
      else
      begin
         ch_on <= next_ch_on;
         ch_src <= next_ch_src;
         ch_div <= next_ch_div;
      end
   end

   // Read mux built from next values, so a read right after a write sees the new data.
   always_comb
   begin
      rd_byte = 8'h00;
      unique case (haddr[31:2])
         COD_SRC_SEL_IDX:
         begin
            // Only the choice bit is held; the rest reads zero.
            rd_byte[COD_LS_CHOICE_BIT] = next_ls_choice;
         end
         COD_OSC_CTL_IDX:
         begin
            // Enable state as the oscillators actually see it.
            rd_byte[COD_EXT_ON_BIT] = next_ext_on;
            rd_byte[COD_LOW_ON_BIT] = next_low_on;
            rd_byte[COD_FAST_ON_BIT] = next_fast_on;
         end
         COD_OUT_A_IDX:
         begin
            // Reserved bits 7 and 1 stay zero.
            rd_byte[COD_OUT_ON_BIT] = next_ch_on[0];
            rd_byte[COD_OUT_SRC_LSB +: 2] = next_ch_src[0];
            rd_byte[COD_OUT_DIV_LSB +: 3] = next_ch_div[0];
         end
         COD_OUT_B_IDX:
         begin
            // Reserved bits 7 and 1 stay zero.
            rd_byte[COD_OUT_ON_BIT] = next_ch_on[1];
            rd_byte[COD_OUT_SRC_LSB +: 2] = next_ch_src[1];
            rd_byte[COD_OUT_DIV_LSB +: 3] = next_ch_div[1];
         end
         default:
         begin
            // Unmapped addresses read zero.
            rd_byte = 8'h00;
         end
      endcase
   end

   // Read data is registered at the address-phase edge and stands in the data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (take && !hwrite)
         hrdata <= {24'h00_0000, rd_byte};
      else
         hrdata <= 32'h0000_0000;
   end

   // Channel A: its own divider running on the selected oscillator.
   cod_out_channel u_out_a
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .osc_level(osc_sync),
      .enable(ch_on[0]),
      .source(ch_src[0]),
      .divider(ch_div[0]),
      .clk_out(clk_out_a)
   );

   // Channel B: identical to channel A.
   cod_out_channel u_out_b
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .osc_level(osc_sync),
      .enable(ch_on[1]),
      .source(ch_src[1]),
      .divider(ch_div[1]),
      .clk_out(clk_out_b)
   );

endmodule : cod_clock_out

// File: tb/cod_clock_out_properties.sv
// Checker for the clock-output block: oscillator enables, read data and output pins.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps

module cod_clock_out_properties
   import cod_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic [1:0] sys_clk_source,
   input wire logic internal_fast_osc_on,
   input wire logic low_speed_osc_on,
   input wire logic ext_high_speed_osc_on,
   input wire logic low_speed_source_choice,
   input wire logic clk_out_a,
   input wire logic clk_out_b
);
   logic dp_wr; // A word write is in its data phase.
   logic dp_rd; // A read is in its data phase.
   logic [31:0] dp_addr; // Address of that data phase.
   logic a_on; // Last enable written to channel A.
   logic b_on; // Last enable written to channel B.
   logic wr_osc;
   logic a_en;
   logic b_en;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // Remembers each accepted transfer for its data phase.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 32'h0;
      end
      else
      begin
         dp_wr <= hsel && htrans[1] && hready && hwrite && hsize == COD_HSIZE_WORD;
         dp_rd <= hsel && htrans[1] && hready && !hwrite;
         dp_addr <= haddr;
      end
   end
   // Tracks the stored enables; a write counts only after its data phase, as in the design.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_on <= 1'b0;
         b_on <= 1'b0;
      end
      else
      begin
         a_on <= a_en;
         b_on <= b_en;
      end
   end
   assign wr_osc = dp_wr && dp_addr == COD_OSC_CTL_ADDR;
   assign a_en = (dp_wr && dp_addr == COD_OUT_A_ADDR) ? hwdata[0] : a_on;
   assign b_en = (dp_wr && dp_addr == COD_OUT_B_ADDR) ? hwdata[0] : b_on;
   reset_state_a: assert property ($rose(hresetn) |-> internal_fast_osc_on && !low_speed_osc_on
      && !ext_high_speed_osc_on && low_speed_source_choice && !clk_out_a && !clk_out_b)
      else $error("outputs differ from reset state");
   ext_write_a: assert property (wr_osc |=> ext_high_speed_osc_on == ($past(hwdata[0])
      || ($past(sys_clk_source) == COD_SRC_EXT && $past(ext_high_speed_osc_on))))
      else $error("external oscillator enable wrong after write");
   ext_keep_a: assert property (ext_high_speed_osc_on && sys_clk_source == COD_SRC_EXT
      |=> ext_high_speed_osc_on) else $error("system clock oscillator was stopped");
   low_keep_a: assert property (low_speed_osc_on && sys_clk_source == COD_SRC_LOW
      |=> low_speed_osc_on) else $error("low-speed oscillator was stopped");
   choice_keep_a: assert property (!(dp_wr && dp_addr == COD_SRC_SEL_ADDR)
      |=> $stable(low_speed_source_choice)) else $error("source choice changed without a write");
   source_choice_a: assert property (dp_wr && dp_addr == COD_SRC_SEL_ADDR
      |=> low_speed_source_choice == $past(hwdata[4])) else $error("source choice not written");
   rsvd_read_a: assert property (dp_rd && (dp_addr == COD_OUT_A_ADDR || dp_addr == COD_OUT_B_ADDR)
      |-> hrdata[31:8] == 24'h0 && !hrdata[7] && !hrdata[1]) else $error("reserved bits read as one");
   a_idle_a: assert property (!a_on && !clk_out_a |=> !clk_out_a)
      else $error("channel A pin rose while disabled");
   b_idle_a: assert property (!b_on && !clk_out_b |=> !clk_out_b)
      else $error("channel B pin rose while disabled");
   a_high_a: assert property ($rose(clk_out_a) |-> clk_out_a[*3])
      else $error("short high pulse on channel A");
   b_low_a: assert property ($fell(clk_out_b) |-> !clk_out_b[*3])
      else $error("short low pulse on channel B");
   cover property (wr_osc && !hwdata[0] && sys_clk_source == COD_SRC_EXT && ext_high_speed_osc_on);
   cover property ($rose(clk_out_a));
   cover property ($rose(clk_out_b));
endmodule : cod_clock_out_properties

// File: tb/cod_osc_partner.sv
// Far side: runs the three oscillators and times the rises of both output pins.
// Assumes a 10 ns hclk; half periods avoid its rising edges, so sampling is exact.
`timescale 1ns/1ps

module cod_osc_partner
(
   input wire logic fast_on,
   input wire logic low_on,
   input wire logic ext_on,
   input wire logic clk_out_a,
   input wire logic clk_out_b,
   output logic fast_clk,
   output logic low_clk,
   output logic ext_clk,
   output int period_a,
   output int period_b
);
   longint last_a = 0; // Time of the last rise on pin A, in ns.
   longint last_b = 0; // Time of the last rise on pin B, in ns.
   // Clocks start low and periods unknown.
   initial
   begin
      fast_clk = 1'b0;
      low_clk = 1'b0;
      ext_clk = 1'b0;
      period_a = 0;
      period_b = 0;
   end
   // A switched-off oscillator stands low, as a stopped one would.
   always #30 fast_clk = fast_on & ~fast_clk;
   always #70 low_clk = low_on & ~low_clk;
   always #50 ext_clk = ext_on & ~ext_clk;
   // Measures the time between successive rises of each pin.
   always @(posedge clk_out_a)
   begin
      period_a = int'($time - last_a);
      last_a = $time;
   end
   always @(posedge clk_out_b)
   begin
      period_b = int'($time - last_b);
      last_b = $time;
   end
endmodule : cod_osc_partner

// File: tb/test_cod_clock_out.sv
// Self-checking bench: register model over AHB-Lite and timed clock outputs.
// Assumes the package, the checker and the partner model are compiled first.
`timescale 1ns/1ps

module test_cod_clock_out
   import cod_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] sys_src = 2'h0; // System clock source seen by the block.
   logic [31:0] hrdata;
   logic hreadyout, hresp, fast_on, low_on, ext_on, choice, out_a, out_b;
   logic fast_clk, low_clk, ext_clk;
   int period_a, period_b, failures = 0, samples_checked = 0, cycles = 0;
   logic [7:0] model [5]; // Expected contents; the last entry is an unmapped word.
   logic [31:0] addrs [5] = '{COD_SRC_SEL_ADDR, COD_OSC_CTL_ADDR, COD_OUT_A_ADDR,
      COD_OUT_B_ADDR, 32'h0001_4188};
   int src_ns [3] = '{60, 140, 100}; // Oscillator periods in ns by source code.
   int idx;
   always #5 hclk = ~hclk;
   cod_clock_out dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sys_clk_source(sys_src),
      .internal_fast_osc_clk(fast_clk), .low_speed_osc_clk(low_clk),
      .ext_high_speed_osc_clk(ext_clk), .internal_fast_osc_on(fast_on),
      .low_speed_osc_on(low_on), .ext_high_speed_osc_on(ext_on),
      .low_speed_source_choice(choice), .clk_out_a(out_a), .clk_out_b(out_b));
   cod_osc_partner part_u (.fast_on(fast_on), .low_on(low_on), .ext_on(ext_on),
      .clk_out_a(out_a), .clk_out_b(out_b), .fast_clk(fast_clk), .low_clk(low_clk),
      .ext_clk(ext_clk), .period_a(period_a), .period_b(period_b));
   // Compares one value and counts it.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Prints the verdict and ends the run.
   task automatic summarize();
      if (failures == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   // One single word transfer; address phase held until hready, then the data phase.
   task automatic xfer(input int i, input logic wr, input logic [7:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= addrs[i];
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : xfer
   // Writes a register and updates the model.
   task automatic reg_wr(input int i, input logic [7:0] d);
      logic [31:0] q;
      xfer(i, 1'b1, d, q);
      case (i)
         0: model[0] = d & 8'h10;
         1: model[1] = (d & 8'h07) | (model[1] & (8'h04 >> sys_src));
         2, 3: model[i] = d & 8'h7d;
         default: ;
      endcase
   endtask : reg_wr
   // Reads a register and compares it with the model.
   task automatic reg_chk(input int i);
      logic [31:0] q;
      xfer(i, 1'b0, 8'h00, q);
      check("register", q, {24'h0, model[i]});
      check("response", 32'(hresp), 32'h0);
   endtask : reg_chk
   // Holds reset for 12 cycles and restores the model's reset values.
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      model = '{8'h10, 8'h04, 8'h00, 8'h00, 8'h00};
      check("reset pins", 32'({fast_on, low_on, ext_on, choice, out_a, out_b}), 32'h24);
   endtask : do_reset
   // A hang ends the run as a failure; the tests need under 25000 cycles.
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 50000)
      begin
         failures++;
         summarize();
      end
   end
   // Main sequence.
   initial
   begin
      void'($urandom(49));
      do_reset();
      for (int i = 0; i < 5; i++)
         reg_chk(i);
      reg_wr(0, 8'h00); // the source is chosen before the oscillator starts
      reg_wr(1, 8'h07);
      reg_chk(0);
      check("enables", 32'({fast_on, low_on, ext_on, choice}), 32'he);
      // Try to stop every oscillator while each is the system clock.
      for (int s = 0; s < 3; s++)
      begin
         sys_src <= s[1:0];
         reg_wr(1, 8'h07);
         reg_wr(1, 8'h00);
         reg_chk(1);
         check("osc pins", 32'({fast_on, low_on, ext_on}), 32'(model[1][2:0]));
      end
      sys_src <= 2'h0;
      reg_wr(1, 8'h07);
      reg_wr(2, 8'hff);
      reg_chk(2);
      repeat (6)
      begin
         idx = 2 + int'($urandom % 2);
         reg_wr(idx, 8'($urandom) & 8'h7d);
         reg_chk(idx);
      end
      // Every divider code, with sources rotating over both channels.
      for (int n = 0; n < 8; n++)
      begin
         reg_wr(2, 8'((n << 4) | ((n % 3) << 2) | 1));
         reg_wr(3, 8'((n << 4) | (((n + 1) % 3) << 2) | 1));
         // The first write may have to wait out a slow random period.
         repeat ((42 << n) + ((n == 0) ? 2000 : 60)) @(posedge hclk);
         check("period a", period_a, src_ns[n % 3] << n);
         check("period b", period_b, src_ns[(n + 1) % 3] << n);
      end
      reg_wr(2, 8'h0d);
      reg_wr(3, 8'h70);
      repeat (2000) @(posedge hclk);
      repeat (20)
      begin
         @(negedge hclk);
         check("pins off", 32'({out_a, out_b}), 32'h0);
      end
      @(posedge hclk);
      do_reset();
      reg_chk(2);
      summarize();
   end
endmodule : test_cod_clock_out

bind cod_clock_out cod_clock_out_properties chk_u (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .sys_clk_source(sys_clk_source),
   .internal_fast_osc_on(internal_fast_osc_on), .low_speed_osc_on(low_speed_osc_on),
   .ext_high_speed_osc_on(ext_high_speed_osc_on),
   .low_speed_source_choice(low_speed_source_choice), .clk_out_a(clk_out_a),
   .clk_out_b(clk_out_b));
